// file: verilog/tcr_consts.vh
// constants for the time constant configuration register slice
// assumes: included by bare name from the design files, nothing else
//
// Function
// - time_constant_one: 8-bit RW, offset 0x02, reset 0x90
// - bits 7:6 pick first capacitance, reset 10
// - bits 4:0 first resistance code, reset 16
// - time_constant_two: 8-bit RW, offset 0x03, reset 0xA0
// - bits 7:6 pick second capacitance, reset 10
// - bits 5:0 second resistance code, reset 32
// - digital_settings: 8-bit, offset 0x04, reset 0x03
`ifndef TCR_CONSTS_VH
`define TCR_CONSTS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TCR_ADDR_W 7
`define TCR_OFF_TC_ONE 7'h02
`define TCR_OFF_TC_TWO 7'h03
`define TCR_OFF_DIG 7'h04
`define TCR_RST_TC_ONE 8'h90
`define TCR_RST_TC_TWO 8'hA0
`define TCR_RST_DIG 8'h03
`define TCR_RD_UNMAPPED 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCR_CAP_HI 7
`define TCR_CAP_LO 6
`define TCR_RES1_HI 4
`define TCR_RES2_HI 5
`define TCR_MINF_HI 7
`define TCR_MINF_LO 4
`define TCR_RESP_HI 2

// ----------------------------------------------------------------
// analogue value scaling (femtofarads, ohms)
// ----------------------------------------------------------------
`define TCR_CAP1_BASE_FF 16'h02EE
`define TCR_CAP2_BASE_FF 16'h0BB8
`define TCR_RES1_BASE_OHM 20'h6_5CE8
`define TCR_RES2_BASE_OHM 20'hC_BDB8
`define TCR_RES_STEP_OHM 20'h0_31E2

// ----------------------------------------------------------------
// register index after address decode
// ----------------------------------------------------------------
`define TCR_IDX_W 2
`define TCR_IDX_NONE 2'h0
`define TCR_IDX_TC_ONE 2'h1
`define TCR_IDX_TC_TWO 2'h2
`define TCR_IDX_DIG 2'h3

// ----------------------------------------------------------------
// serial frame
// ----------------------------------------------------------------
`define TCR_CMD_RD_BIT 7
`define TCR_CNT_W 5
`define TCR_CNT_CMD 5'h08
`define TCR_CNT_LAST 5'h10
`define TCR_CNT_ONE 5'h01

`endif

// file: verilog/tcr_pin_sync.v
// three-flop input synchroniser with agreement filter
// assumes: pin is asynchronous to clk; reset is synchronous
`timescale 1ns/1ps
module tcr_pin_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire clk,
  input wire reset,
  input wire pin,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // first stage feeds only the second: metastability containment
  always @(posedge clk) begin
    if (reset) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule // tcr_pin_sync

// file: verilog/tcr_regs.v
// serial-port register slice: two time constants and digital settings
// assumes: 4-wire serial host, mode 0, sclk well below clk / 8
`timescale 1ns/1ps
`include "tcr_consts.vh"
module tcr_regs (
  input wire clk,
  input wire reset,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_sdi,
  output reg spi_sdo_q,
  output reg spi_sdo_oe_q,
  output reg [1:0] first_cap_select,
  output reg [4:0] first_res_code,
  output reg [1:0] second_cap_select,
  output reg [5:0] second_res_code,
  output reg [3:0] min_freq_code,
  output reg [2:0] resp_time_code,
  output reg [15:0] first_cap_ff,
  output reg [19:0] first_res_ohm,
  output reg [15:0] second_cap_ff,
  output reg [19:0] second_res_ohm
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // capacitance doubles per code step
  function [15:0] cap_ff;
    input [15:0] base;
    input [1:0] code;
    begin
      cap_ff = base << code;
    end
  endfunction

  // resistance falls linearly with the code
  function [19:0] res_ohm;
    input [19:0] base;
    input [5:0] code;
    reg [25:0] prod;
    begin
      prod = `TCR_RES_STEP_OHM * code;
      res_ohm = base - prod[19:0];
    end
  endfunction

  // one decode for read mux and write strobe, so they cannot disagree
  function [`TCR_IDX_W-1:0] reg_index;
    input [`TCR_ADDR_W-1:0] addr;
    begin
      case (addr)
        `TCR_OFF_TC_ONE: reg_index = `TCR_IDX_TC_ONE;
        `TCR_OFF_TC_TWO: reg_index = `TCR_IDX_TC_TWO;
        `TCR_OFF_DIG: reg_index = `TCR_IDX_DIG;
        default: reg_index = `TCR_IDX_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire cs_n_s;
  wire sclk_s;
  wire sdi_s;

  tcr_pin_sync #(.RST_VAL(1'b1)) u_cs (
    .clk(clk),
    .reset(reset),
    .pin(spi_cs_n),
    .level_q(cs_n_s)
  );

  tcr_pin_sync #(.RST_VAL(1'b0)) u_sclk (
    .clk(clk),
    .reset(reset),
    .pin(spi_sclk),
    .level_q(sclk_s)
  );

  tcr_pin_sync #(.RST_VAL(1'b0)) u_sdi (
    .clk(clk),
    .reset(reset),
    .pin(spi_sdi),
    .level_q(sdi_s)
  );

  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  reg sclk_prev_q;
  reg [`TCR_CNT_W-1:0] cnt_q;
  reg [7:0] rx_q;
  reg [7:0] cmd_q;
  reg [7:0] tx_q;
  reg [7:0] tc_one_q;
  reg [7:0] tc_two_q;
  reg [7:0] dig_q;
  reg [7:0] rd_data;

  wire sel = ~cs_n_s;
  wire rise = sel & sclk_s & ~sclk_prev_q;
  wire fall = sel & ~sclk_s & sclk_prev_q;
  wire [7:0] rx_next = {rx_q[6:0], sdi_s};
  wire [`TCR_ADDR_W-1:0] cmd_addr = rx_next[`TCR_ADDR_W-1:0];
  wire is_read = cmd_q[`TCR_CMD_RD_BIT];
  // commit on the 16th rise only; a frame cut short writes nothing
  wire wr_commit = rise & (cnt_q == `TCR_CNT_LAST - `TCR_CNT_ONE) &
    ~is_read;

  // read mux over the current command byte being completed
  // unmapped offsets read as zero and swallow writes
  always @* begin
    case (reg_index(cmd_addr))
      `TCR_IDX_TC_ONE: rd_data = tc_one_q;
      `TCR_IDX_TC_TWO: rd_data = tc_two_q;
      `TCR_IDX_DIG: rd_data = dig_q;
      default: rd_data = `TCR_RD_UNMAPPED;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
      cnt_q <= {`TCR_CNT_W{1'b0}};
      rx_q <= 8'h00;
      cmd_q <= 8'h00;
      tx_q <= 8'h00;
    end else begin
      sclk_prev_q <= sclk_s;
      if (!sel) begin
        // deselect aborts any partial frame
        cnt_q <= {`TCR_CNT_W{1'b0}};
      end else if (rise && cnt_q != `TCR_CNT_LAST) begin
        rx_q <= rx_next;
        cnt_q <= cnt_q + `TCR_CNT_ONE;
        if (cnt_q == `TCR_CNT_CMD - `TCR_CNT_ONE) begin
          cmd_q <= rx_next;
          tx_q <= rd_data;
        end
      // shift from the 9th fall on: bit 7 must stand through the 9th rise
      end else if (fall && cnt_q > `TCR_CNT_CMD) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // sdo driven only during the data byte of a read
  always @(posedge clk) begin
    if (reset) begin
      spi_sdo_q <= 1'b0;
      spi_sdo_oe_q <= 1'b0;
    end else begin
      spi_sdo_q <= tx_q[7];
      spi_sdo_oe_q <= sel && is_read && cnt_q >= `TCR_CNT_CMD;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reserved bits are stored as written; software keeps them zero
  always @(posedge clk) begin
    if (reset) begin
      tc_one_q <= `TCR_RST_TC_ONE;
      tc_two_q <= `TCR_RST_TC_TWO;
      dig_q <= `TCR_RST_DIG;
    end else if (wr_commit) begin
      case (reg_index(cmd_q[`TCR_ADDR_W-1:0]))
        `TCR_IDX_TC_ONE: tc_one_q <= rx_next;
        `TCR_IDX_TC_TWO: tc_two_q <= rx_next;
        `TCR_IDX_DIG: dig_q <= rx_next;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // field outputs to the front end
  // ----------------------------------------------------------------
  // registered so the analogue side never sees decode glitches
  always @(posedge clk) begin
    if (reset) begin
      first_cap_select <= 2'h0;
      first_res_code <= 5'h00;
      second_cap_select <= 2'h0;
      second_res_code <= 6'h00;
      min_freq_code <= 4'h0;
      resp_time_code <= 3'h0;
    end else begin
      first_cap_select <= tc_one_q[`TCR_CAP_HI:`TCR_CAP_LO];
      first_res_code <= tc_one_q[`TCR_RES1_HI:0];
      second_cap_select <= tc_two_q[`TCR_CAP_HI:`TCR_CAP_LO];
      second_res_code <= tc_two_q[`TCR_RES2_HI:0];
      min_freq_code <= dig_q[`TCR_MINF_HI:`TCR_MINF_LO];
      resp_time_code <= dig_q[`TCR_RESP_HI:0];
    end
  end

  // ----------------------------------------------------------------
  // analogue values
  // ----------------------------------------------------------------
  // taken from the registers, so values and codes change on one edge
  always @(posedge clk) begin
    if (reset) begin
      first_cap_ff <= 16'h0000;
      first_res_ohm <= 20'h0_0000;
      second_cap_ff <= 16'h0000;
      second_res_ohm <= 20'h0_0000;
    end else begin
      first_cap_ff <= cap_ff(`TCR_CAP1_BASE_FF,
        tc_one_q[`TCR_CAP_HI:`TCR_CAP_LO]);
      second_cap_ff <= cap_ff(`TCR_CAP2_BASE_FF,
        tc_two_q[`TCR_CAP_HI:`TCR_CAP_LO]);
      first_res_ohm <= res_ohm(`TCR_RES1_BASE_OHM,
        {1'b0, tc_one_q[`TCR_RES1_HI:0]});
      second_res_ohm <= res_ohm(`TCR_RES2_BASE_OHM,
        tc_two_q[`TCR_RES2_HI:0]);
    end
  end
endmodule // tcr_regs

// file: tb/tcr_regs_checker.sv
// checker for the field and analogue outputs of the register slice
// assumes: bound onto tcr_regs, one clock, synchronous reset
`timescale 1ns/1ps
module tcr_regs_checker (
  input wire clk,
  input wire reset,
  input wire spi_cs_n,
  input wire spi_sdo_oe_q,
  input wire [1:0] first_cap_select,
  input wire [4:0] first_res_code,
  input wire [1:0] second_cap_select,
  input wire [5:0] second_res_code,
  input wire [3:0] min_freq_code,
  input wire [2:0] resp_time_code,
  input wire [15:0] first_cap_ff,
  input wire [19:0] first_res_ohm,
  input wire [15:0] second_cap_ff,
  input wire [19:0] second_res_ohm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----
  // properties
  // ----
  // decoded fields load on the first edge after release; checked two edges on
  sequence rel_s; $fell(reset) ##2 1'b1; endsequence
  sequence ok_s; !$past(reset) && !$past(reset, 2); endsequence
  // writes land only inside a frame, so a quiet bus means steady fields
  sequence quiet_s; (spi_cs_n && !reset)[*8]; endsequence
  rst_one_a: assert property (rel_s |->
    first_cap_select == 2'h2 && first_res_code == 5'h10) else $error("rst1");
  rst_two_a: assert property (rel_s |->
    second_cap_select == 2'h2 && second_res_code == 6'h20) else $error("rst2");
  rst_dig_a: assert property (rel_s |->
    min_freq_code == 4'h0 && resp_time_code == 3'h3) else $error("rst3");
  cap_one_a: assert property (ok_s |->
    first_cap_ff == (16'h02ee << first_cap_select)) else $error("cap1");
  cap_two_a: assert property (ok_s |->
    second_cap_ff == (16'h0bb8 << second_cap_select)) else $error("cap2");
  res_one_a: assert property (ok_s |->
    first_res_ohm == 20'h6_5ce8 - 20'h0_31e2 * first_res_code)
    else $error("res1");
  res_two_a: assert property (ok_s |->
    second_res_ohm == 20'hc_bdb8 - 20'h0_31e2 * second_res_code)
    else $error("res2");
  hold_quiet_a: assert property (quiet_s |=> $stable({first_cap_select,
    first_res_code, second_cap_select, second_res_code, min_freq_code,
    resp_time_code})) else $error("hold");
  oe_in_frame_a: assert property ($rose(spi_sdo_oe_q) |->
    !spi_cs_n) else $error("oe raised outside a frame");
  oe_release_a: assert property ($rose(spi_cs_n) |->
    ##[1:8] !spi_sdo_oe_q) else $error("oe not released");
endmodule // tcr_regs_checker

// file: tb/tcr_spi_host.sv
// host model: serial master sending one frame per call
// assumes: clk is the device clock; caller waits for the call to end
`timescale 1ns/1ps
module tcr_spi_host (
  input wire clk,
  input wire [3:0] gap,
  input wire spi_sdo_q,
  output reg spi_cs_n = 1'b1,
  output reg spi_sclk = 1'b0,
  output reg spi_sdi = 1'b0,
  output reg [7:0] rd_q = 8'h00,
  output reg done_q = 1'b0
);
  integer i;
  // phases of ten clocks or more, so the pin synchroniser sees each one
  task xfer(input [15:0] fr);
    begin
      @(posedge clk);
      spi_cs_n <= 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        repeat (10 + gap) @(posedge clk);
        spi_sdi <= fr[i];
        repeat (10) @(posedge clk);
        spi_sclk <= 1'b1;
        if (i < 8) rd_q <= {rd_q[6:0], spi_sdo_q};
        repeat (10) @(posedge clk);
        spi_sclk <= 1'b0;
      end
      repeat (10) @(posedge clk);
      spi_cs_n <= 1'b1;
      spi_sdi <= ~spi_sdi;
      done_q <= fr[15];
      @(posedge clk);
      done_q <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask
endmodule // tcr_spi_host

// file: tb/tcr_regs_tb.sv
// testbench: host frames into the register slice, reads checked by queue
// assumes: design, host model and checker compiled before this file
`timescale 1ns/1ps
module tcr_regs_tb;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [3:0] gap = 4'h0;
  reg [31:0] seed = 32'h46a0_5bc9;
  reg [7:0] r;
  reg [7:0] exp_q[$];
  integer fails = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer k;
  wire cs_n, sclk, sdi, sdo, done, oe;
  // a released sdo line shows the inverse, so a late enable spoils reads
  wire sdo_line = oe ? sdo : ~sdo;
  wire [1:0] fcs, scs;
  wire [4:0] frc;
  wire [5:0] src;
  wire [3:0] mfc;
  wire [2:0] rtc;
  wire [7:0] rd;
  always #12.5 clk = ~clk;
  tcr_regs tcr_regs_inst (.clk(clk), .reset(reset), .spi_cs_n(cs_n),
    .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo_q(sdo), .spi_sdo_oe_q(oe),
    .first_cap_select(fcs), .first_res_code(frc), .second_cap_select(scs),
    .second_res_code(src), .min_freq_code(mfc), .resp_time_code(rtc),
    .first_cap_ff(), .first_res_ohm(), .second_cap_ff(), .second_res_ohm());
  tcr_spi_host tcr_spi_host_inst (.clk(clk), .gap(gap), .spi_sdo_q(sdo_line),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .rd_q(rd),
    .done_q(done));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task xfer(input [15:0] fr);
    begin
      seed = xs(seed);
      gap <= seed[3:0];
      tcr_spi_host_inst.xfer(fr);
    end
  endtask
  task rd_chk(input [6:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      xfer({1'b1, a, 8'h00});
    end
  endtask
  task cmp_byte(input [7:0] got, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (got !== e) begin
        fails = fails + 1;
        $display("FAIL %0t read %h want %h", $time, got, e);
      end
    end
  endtask
  task cmp_code(input [7:0] got, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (got !== e) begin
        fails = fails + 1;
        $display("FAIL %0t field %h want %h", $time, got, e);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    if (done) cmp_byte(rd, exp_q.pop_front());
  end
  // a frame is under a thousand clocks, so this is far past a hang
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    rd_chk(7'h02, 8'h90);
    rd_chk(7'h03, 8'ha0);
    rd_chk(7'h04, 8'h03);
    $display("test reset values done");
    for (k = 0; k < 4; k = k + 1) begin
      seed = xs(seed);
      r = (k == 0) ? 8'h00 : (k == 3) ? 8'hff : seed[7:0];
      xfer({8'h02, k[1:0], 1'b0, r[4:0]});
      xfer({8'h03, k[1:0], r[5:0]});
      cmp_code({fcs, 1'b0, frc}, {k[1:0], 1'b0, r[4:0]});
      cmp_code({scs, src}, {k[1:0], r[5:0]});
      rd_chk(7'h02, {k[1:0], 1'b0, r[4:0]});
      rd_chk(7'h03, {k[1:0], r[5:0]});
    end
    $display("test field codes done");
    seed = xs(seed);
    r = seed[15:8];
    xfer({8'h04, r});
    cmp_code({mfc, 1'b0, rtc}, {r[7:4], 1'b0, r[2:0]});
    rd_chk(7'h04, r);
    xfer({8'h05, 8'h5a});
    rd_chk(7'h05, 8'h00);
    rd_chk(7'h02, 8'hdf);
    $display("test write and unmapped done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    rd_chk(7'h02, 8'h90);
    $display("test second reset done");
    print_verdict;
  end
endmodule // tcr_regs_tb
bind tcr_regs tcr_regs_checker tcr_regs_checker_inst (.*);
